// [hw/aesc_pkg.sv]
package aesc_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0] AESC_ADDR_STATUS    = 8'h82;
    localparam logic [7:0] AESC_ADDR_CONTROL   = 8'h83;
    localparam logic [7:0] AESC_ADDR_BLK_FIRST = 8'h84;
    localparam logic [7:0] AESC_ADDR_BLK_LAST  = 8'h93;
    localparam logic [7:0] AESC_ADDR_ALIAS     = 8'h94;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int         AESC_STAT_ERR_BIT  = 7;
    localparam int         AESC_STAT_DONE_BIT = 0;
    localparam int         AESC_CTL_START_BIT = 7;
    localparam int         AESC_CTL_MODE_HI   = 6;
    localparam int         AESC_CTL_MODE_LO   = 4;
    localparam int         AESC_CTL_DIR_BIT   = 3;
    localparam logic [7:0] AESC_CTL_RW_MASK   = 8'h78;
    localparam logic [7:0] AESC_STATUS_RESET  = 8'h00;
    localparam logic [7:0] AESC_CONTROL_RESET = 8'h00;
    localparam logic [2:0] AESC_MODE_ECB      = 3'h0;
    localparam logic [2:0] AESC_MODE_KEY      = 3'h1;
    localparam logic [2:0] AESC_MODE_CBC      = 3'h2;
    localparam int         AESC_BLOCK_BYTES   = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int AESC_CLK_MHZ       = 100;
    localparam int AESC_RUN_MAX_US    = 24;
    localparam int AESC_RUN_MAX_CYC   = AESC_RUN_MAX_US * AESC_CLK_MHZ;
    localparam int AESC_RUN_DEF_CYC   = 2340;

    typedef enum logic [2:0] {
        AESC_IDLE = 3'b001,
        AESC_RUN  = 3'b010,
        AESC_KEY  = 3'b100
    } aesc_state_t;

endpackage

// [hw/aesc_run_timer.sv]
`timescale 1ns/100ps
`default_nettype none

// Counts the processing time of one run; abort stops it at once
module aesc_run_timer
    import aesc_pkg::*;
#(
    parameter int RUN_CYCLES = AESC_RUN_DEF_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic launch,
    input  wire logic abort,
    // Status
    output logic      busy,
    output logic      finish
);
    localparam int CW = $clog2(RUN_CYCLES + 1);

    // Refused at elaboration: a run longer than the bound breaks the done deadline
    if (RUN_CYCLES < 1 || RUN_CYCLES > AESC_RUN_MAX_CYC) begin : g_bad_run_cycles
        $error("aesc_run_timer: RUN_CYCLES out of range");
    end

    logic [CW-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            count_reg <= '0;
            busy      <= 1'b0;
            finish    <= 1'b0;
        end else if (launch) begin
            count_reg <= CW'(RUN_CYCLES - 1);
            busy      <= 1'b1;
            finish    <= 1'b0;
        end else if (busy) begin
            finish    <= (count_reg == '0);
            busy      <= (count_reg != '0);
            count_reg <= (count_reg == '0) ? '0 : count_reg - 1'b1;
        end else begin
            finish    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [hw/aesc_engine_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Error flag on busy control access, short read
// - Error bit reads one after module error
// - Done bit reads one after completion
// - Control access while running aborts run
// - Start bit write launches run
// - Bits 6:4 select ECB, key, CBC
// - Bit 3 selects encrypt or ECB decrypt
// - Address 0x94 mirrors the control register
// - Burst write to mirror starts processing
// - Done within 24 microseconds of start
// - Block space holds key or data
// - Deepest sleep resets all registers
// - Write returns previous byte one later
module aesc_engine_ctrl
    import aesc_pkg::*;
#(
    parameter int RUN_CYCLES = AESC_RUN_DEF_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       deepestSleepState,
    // SRAM access port (byte strobes from the SPI front end)
    input  wire logic       accStart,
    input  wire logic       accEnd,
    input  wire logic       accWrite,
    input  wire logic       accRead,
    input  wire logic [7:0] accAddr,
    input  wire logic [7:0] accWdata,
    // Read data and status
    output logic [7:0]      accRdata,
    output logic [7:0]      accOutData,
    output logic            cipherBusy,
    output logic [2:0]      cipherMode,
    output logic            cipherDecrypt,
    output logic            keyValid
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic isCtl(input logic [7:0] a);
        return (a == AESC_ADDR_CONTROL) || (a == AESC_ADDR_ALIAS);
    endfunction

    function automatic logic modeLegal(input logic [2:0] m);
        return (m == AESC_MODE_ECB) || (m == AESC_MODE_KEY) || (m == AESC_MODE_CBC);
    endfunction

    function automatic logic isBlk(input logic [7:0] a);
        return (a >= AESC_ADDR_BLK_FIRST) && (a <= AESC_ADDR_BLK_LAST);
    endfunction

    logic        clr;
    logic        ctlAcc;
    logic        ctlWr;
    logic        launch;
    logic        busy;
    logic        finish;
    logic        modeOk;
    logic [3:0]  blkIdx;
    logic [4:0]  readCnt_reg;
    logic [7:0]  prevByte_reg;
    logic [7:0]  control_reg;
    logic        done_reg;
    logic        err_reg;
    logic [7:0]  blkMem [AESC_BLOCK_BYTES];
    logic [7:0]  keyMem [AESC_BLOCK_BYTES];
    aesc_state_t state_reg;

    assign clr    = rst || deepestSleepState;
    assign ctlAcc = isCtl(accAddr) && (accWrite || accRead);
    assign ctlWr  = isCtl(accAddr) && accWrite;
    assign blkIdx = 4'(accAddr - AESC_ADDR_BLK_FIRST);
    assign modeOk = modeLegal(accWdata[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO])
                 && !((accWdata[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO] == AESC_MODE_CBC)
                      && accWdata[AESC_CTL_DIR_BIT]);
    // Reserved mode codes and CBC decrypt are refused rather than run
    assign launch = ctlWr && accWdata[AESC_CTL_START_BIT] && !busy && modeOk;

    // ------------------------------------------------------------
    // Run timer
    // ------------------------------------------------------------
    aesc_run_timer #(
        .RUN_CYCLES (RUN_CYCLES)
    ) u_timer (
        .clk    (clk),
        .rst    (clr),
        .launch (launch),
        .abort  (ctlAcc && busy),
        .busy   (busy),
        .finish (finish)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            control_reg <= AESC_CONTROL_RESET;
        end else if (ctlWr && !busy && modeLegal(accWdata[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO])) begin
            // A reserved mode code is dropped whole, so the core never sees one
            control_reg <= accWdata & AESC_CTL_RW_MASK;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
        end else if (launch) begin
            done_reg <= 1'b0;
        end
    end

    // Short block read counted per access; checked when the access ends
    always_ff @(posedge clk) begin
        if (clr || accStart) begin
            readCnt_reg <= '0;
        end else if (accRead && isBlk(accAddr) && readCnt_reg != 5'(AESC_BLOCK_BYTES)) begin
            readCnt_reg <= readCnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            err_reg <= 1'b0;
        end else if ((ctlAcc && busy)
                  || (accEnd && readCnt_reg != '0 && readCnt_reg < 5'(AESC_BLOCK_BYTES))) begin
            err_reg <= 1'b1;
        end else if (launch) begin
            err_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Block space and key store
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            for (int i = 0; i < AESC_BLOCK_BYTES; i++) begin
                blkMem[i] <= 8'h00;
                keyMem[i] <= 8'h00;
            end
        end else if (accWrite && isBlk(accAddr)) begin
            if (control_reg[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO] == AESC_MODE_KEY) begin
                keyMem[blkIdx] <= accWdata;
            end else begin
                blkMem[blkIdx] <= accWdata;
            end
        end
    end

    // Previous content is captured on the write and shown one byte later
    always_ff @(posedge clk) begin
        if (clr) begin
            prevByte_reg <= 8'h00;
            accOutData   <= 8'h00;
        end else if (accWrite && accAddr >= AESC_ADDR_STATUS && accAddr <= AESC_ADDR_ALIAS) begin
            accOutData   <= prevByte_reg;
            prevByte_reg <= isBlk(accAddr) ? blkMem[blkIdx] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            accRdata <= 8'h00;
        end else if (accRead) begin
            if (accAddr == AESC_ADDR_STATUS) begin
                accRdata <= {err_reg, 6'h00, done_reg};
            end else if (isCtl(accAddr)) begin
                accRdata <= control_reg;
            end else if (isBlk(accAddr)) begin
                accRdata <= blkMem[blkIdx];
            end else begin
                accRdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            state_reg <= AESC_IDLE;
            keyValid  <= 1'b0;
        end else begin
            unique case (state_reg)
                AESC_IDLE: begin
                    if (launch) begin
                        state_reg <= (accWdata[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO] == AESC_MODE_KEY)
                                   ? AESC_KEY : AESC_RUN;
                    end
                end
                AESC_RUN: begin
                    if (!busy && !launch) begin
                        state_reg <= AESC_IDLE;
                    end
                end
                AESC_KEY: begin
                    if (finish) begin
                        keyValid <= 1'b1;
                    end
                    if (!busy && !launch) begin
                        state_reg <= AESC_IDLE;
                    end
                end
                default: begin
                    state_reg <= AESC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            cipherBusy    <= 1'b0;
            cipherMode    <= AESC_MODE_ECB;
            cipherDecrypt <= 1'b0;
        end else begin
            cipherBusy    <= busy;
            cipherMode    <= control_reg[AESC_CTL_MODE_HI:AESC_CTL_MODE_LO];
            cipherDecrypt <= control_reg[AESC_CTL_DIR_BIT];
        end
    end

endmodule
`default_nettype wire

// [bench/aesc_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module aesc_checker
    import aesc_pkg::*;
#(
    parameter int RUN_CYCLES = AESC_RUN_DEF_CYC
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       deepestSleepState,
    // Access port
    input wire logic       accStart,
    input wire logic       accEnd,
    input wire logic       accWrite,
    input wire logic       accRead,
    input wire logic [7:0] accAddr,
    input wire logic [7:0] accWdata,
    // Results
    input wire logic [7:0] accRdata,
    input wire logic [7:0] accOutData,
    input wire logic       cipherBusy,
    input wire logic [2:0] cipherMode,
    input wire logic       cipherDecrypt,
    input wire logic       keyValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || deepestSleepState);
    logic [15:0] busyCnt_reg;
    wire logic   ctlHit = (accAddr == AESC_ADDR_CONTROL) || (accAddr == AESC_ADDR_ALIAS);
    // A counter, not a long repetition, bounds the run length
    always_ff @(posedge clk) begin
        busyCnt_reg <= (rst || deepestSleepState || !cipherBusy) ? 16'h0000 : busyCnt_reg + 16'h0001;
    end
    sequence s_launch;
        accWrite && ctlHit && accWdata == 8'h80 && !cipherBusy;
    endsequence
    sequence s_ctl_touch;
        (accRead || accWrite) && ctlHit && cipherBusy;
    endsequence
    a_launch_runs: assert property (s_launch |-> ##2 cipherBusy)
        else $error("start did not launch");
    a_touch_aborts: assert property (s_ctl_touch |-> ##[1:3] !cipherBusy)
        else $error("busy control access did not abort");
    a_run_bounded: assert property (busyCnt_reg <= 16'(RUN_CYCLES + 1))
        else $error("run too long");
    a_status_reserved: assert property (accRead && accAddr == AESC_ADDR_STATUS |=> accRdata[6:1] == 6'h00)
        else $error("status reserved bits set");
    a_ctrl_readback: assert property (accRead && ctlHit && !cipherBusy |=> (accRdata & 8'h87) == 8'h00)
        else $error("control start or reserved bits read set");
    a_mode_legal: assert property (cipherMode <= AESC_MODE_CBC)
        else $error("reserved mode taken");
    a_dir_ecb_only: assert property (cipherBusy && cipherDecrypt |-> cipherMode == AESC_MODE_ECB)
        else $error("decrypt outside ECB");
    a_sleep_clears: assert property (@(posedge clk) disable iff (rst)
        deepestSleepState |=> accRdata == 8'h00 && !cipherBusy && !keyValid)
        else $error("sleep did not clear");
endmodule
`default_nettype wire

// [bench/aesc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module aesc_host_model (
    // Clock
    input  wire logic clk,
    // Access strobes
    output logic       accStart,
    output logic       accEnd,
    output logic       accWrite,
    output logic       accRead,
    output logic [7:0] accAddr,
    output logic [7:0] accWdata
);
    initial begin
        {accStart, accEnd, accWrite, accRead} = 4'h0;
        {accAddr, accWdata} = 16'h0000;
    end
    // One byte per cycle, changed at the falling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {accStart, accEnd, accWrite, accRead} = {2'b00, w, !w};
        accAddr = a;
        accWdata = d;
    endtask
    // Released lines toggle so stale values are never trusted
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            {accStart, accEnd, accWrite, accRead} = 4'h0;
            accAddr = ~accAddr;
            accWdata = ~accWdata;
        end
    endtask
    task automatic mark(input logic s);
        @(negedge clk);
        {accStart, accEnd, accWrite, accRead} = {s, !s, 2'b00};
    endtask
endmodule
`default_nettype wire

// [bench/test_aes_engine_control_status.sv]
`timescale 1ns/100ps
`default_nettype none
module test_aes_engine_control_status
    import aesc_pkg::*;
;
    localparam int RUN_CYCLES = 20;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       deepestSleepState = 1'b0;
    wire logic  accStart, accEnd, accWrite, accRead, cipherBusy, cipherDecrypt, keyValid;
    wire logic [7:0] accAddr, accWdata, accRdata, accOutData;
    wire logic [2:0] cipherMode;
    logic [7:0] blk [17];
    logic [8:0] noteQ [$];
    logic [8:0] note;
    logic       seenRd = 1'b0;
    logic       seenWr = 1'b0;
    int         bad_count = 0;
    int         check_count = 0;
    always #5 clk = ~clk;
    aesc_host_model u_host (
        .clk      (clk),
        .accStart (accStart),
        .accEnd   (accEnd),
        .accWrite (accWrite),
        .accRead  (accRead),
        .accAddr  (accAddr),
        .accWdata (accWdata)
    );
    aesc_engine_ctrl #(
        .RUN_CYCLES (RUN_CYCLES)
    ) u_dut (
        .clk               (clk),
        .rst               (rst),
        .deepestSleepState (deepestSleepState),
        .accStart          (accStart),
        .accEnd            (accEnd),
        .accWrite          (accWrite),
        .accRead           (accRead),
        .accAddr           (accAddr),
        .accWdata          (accWdata),
        .accRdata          (accRdata),
        .accOutData        (accOutData),
        .cipherBusy        (cipherBusy),
        .cipherMode        (cipherMode),
        .cipherDecrypt     (cipherDecrypt),
        .keyValid          (keyValid)
    );
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Each access leaves a note; bit 8 marks a known answer
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] n);
        noteQ.push_back(n);
        u_host.acc(w, a, d);
    endtask
    always @(posedge clk) begin
        seenRd <= accRead;
        seenWr <= accWrite;
    end
    always @(negedge clk) begin
        if ((seenRd || seenWr) && noteQ.size() > 0) begin
            note = noteQ.pop_front();
            if (note[8]) check(seenRd ? accRdata : accOutData, note[7:0]);
        end
    end
    // Poll status only, since touching control would abort the run
    task automatic wait_done();
        for (int n = 0; n < 20 && accRdata[0] !== 1'b1; n++) begin
            op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h000);
            u_host.idle(1);
        end
    endtask
    task automatic burst(input logic [7:0] last, input logic chk);
        logic [7:0] nxt;
        logic [7:0] prev;
        prev = 8'h00;
        u_host.mark(1'b1);
        op(1'b1, AESC_ADDR_CONTROL, 8'h00, 9'h000);
        for (int i = 0; i < 17; i++) begin
            nxt = (i < 16) ? 8'($urandom) : last;
            op(1'b1, AESC_ADDR_BLK_FIRST + 8'(i), nxt, {chk && i > 0, prev});
            prev = blk[i];
            blk[i] = nxt;
        end
        u_host.mark(1'b0);
        u_host.idle(2);
    endtask
    initial begin
        logic [7:0] v;
        void'($urandom(22643));
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h100);
        op(1'b0, AESC_ADDR_CONTROL, 8'h00, 9'h100);
        for (int m = 0; m < 6; m++) begin
            v = {1'b0, 3'(m / 2), 1'(m), 3'h7};
            op(1'b1, AESC_ADDR_CONTROL, v, 9'h000);
            op(1'b0, AESC_ADDR_ALIAS, 8'h00, {1'b1, v & AESC_CTL_RW_MASK});
        end
        burst(8'h00, 1'b0);
        burst(8'h80, 1'b1);
        wait_done();
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h101);
        op(1'b1, AESC_ADDR_CONTROL, 8'h88, 9'h000);
        u_host.idle(3);
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h100);
        op(1'b0, AESC_ADDR_CONTROL, 8'h00, 9'h000);
        u_host.idle(RUN_CYCLES + 10);
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h180);
        op(1'b1, AESC_ADDR_ALIAS, 8'h90, 9'h000);
        wait_done();
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h101);
        check({7'h00, keyValid}, 8'h01);
        check({4'h0, cipherDecrypt, cipherMode}, {4'h0, 1'b0, AESC_MODE_KEY});
        u_host.mark(1'b1);
        for (int i = 0; i < 15; i++) op(1'b0, AESC_ADDR_BLK_FIRST + 8'(i), 8'h00, 9'h000);
        u_host.mark(1'b0);
        u_host.idle(2);
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h181);
        op(1'b1, AESC_ADDR_CONTROL, 8'hA8, 9'h000);
        op(1'b1, AESC_ADDR_CONTROL, 8'hB0, 9'h000);
        u_host.idle(4);
        check({7'h00, cipherBusy}, 8'h00);
        check({4'h0, cipherDecrypt, cipherMode}, {4'h0, 1'b1, AESC_MODE_CBC});
        op(1'b0, AESC_ADDR_ALIAS, 8'h00, 9'h128);
        u_host.idle(1);
        deepestSleepState = 1'b1;
        u_host.idle(1);
        deepestSleepState = 1'b0;
        op(1'b0, AESC_ADDR_CONTROL, 8'h00, 9'h100);
        op(1'b0, AESC_ADDR_STATUS, 8'h00, 9'h100);
        u_host.idle(2);
        final_report();
    end
    // The test needs about two hundred cycles; far beyond that is a hang
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule
bind aesc_engine_ctrl aesc_checker #(
    .RUN_CYCLES (RUN_CYCLES)
) u_chk (
    .clk               (clk),
    .rst               (rst),
    .deepestSleepState (deepestSleepState),
    .accStart          (accStart),
    .accEnd            (accEnd),
    .accWrite          (accWrite),
    .accRead           (accRead),
    .accAddr           (accAddr),
    .accWdata          (accWdata),
    .accRdata          (accRdata),
    .accOutData        (accOutData),
    .cipherBusy        (cipherBusy),
    .cipherMode        (cipherMode),
    .cipherDecrypt     (cipherDecrypt),
    .keyValid          (keyValid)
);
`default_nettype wire
